// *** bench/rht_properties.sv ***
// Checker for the two-wire link between sensor end and master end.
// Assumes both ends run on clk and the signals come from the interface.
`timescale 1ns/1ps
module rht_properties (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl_m_oe,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  idle_release_a: assert property ($rose(rstn) |-> !scl_m_oe && !sda_m_oe && !sda_s_oe)
    else $error("link busy after reset");
  // The sensor may only change its drive while the clock is low, or it fakes a start or a stop.
  sensor_edge_a: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("sensor changed data with clock high");
  scl_low_a: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");
  scl_high_a: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  scl_bound_a: assert property ($fell(scl) |-> ##[8:100] $rose(scl))
    else $error("clock stuck low");
  start_hold_a: assert property ($fell(sda) && scl |-> scl [*8])
    else $error("start not held");
  stop_quiet_a: assert property ($rose(sda) && scl |-> !sda_s_oe [*8])
    else $error("sensor drives after stop");
  sensor_free_a: assert property ($rose(sda_s_oe) |-> ##[1:700] !sda_s_oe)
    else $error("sensor holds data line");
endmodule // rht_properties

// *** bench/rht_tb.sv ***
// Testbench joining the sensor end and the master end over the link.
// Assumes shortened timer parameters; expectations follow from them.
`timescale 1ns/1ps
`include "rht_params.svh"
module rht_tb;
  import rht_pkg::*;
  // Arbitrary identification value.
  localparam logic [31:0] ID = 32'hc0de_0a5e;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [13:0] hum_code = 14'h2a5c;
  logic [13:0] temp_code = 14'h1357;
  logic meas_active;
  logic prog_mode;
  rht_res_t hum_res;
  rht_res_t temp_res;
  logic [31:0] d;
  int fails = 0;
  int tests_run = 0;
  rht_if link ();
  always #20 clk = ~clk;
  // The window is shortened to 8000 cycles, still long enough for the first fetch and the entry frame to fit inside it.
  rht_sensor #(.WIN_CYC(8000), .NVW_CYC(200), .MEAS_CYC(300), .ID_VALUE(ID)) rht_sensor_i (
    .clk(clk), .rstn(rstn), .bus(link.sensor), .hum_code(hum_code), .temp_code(temp_code),
    .meas_active(meas_active), .prog_mode(prog_mode), .hum_res(hum_res), .temp_res(temp_res));
  rht_master #(.NVW_CYC(200)) rht_master_i (.clk(clk), .rstn(rstn), .bus(link.master),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  rht_properties rht_properties_i (.clk(clk), .rstn(rstn), .scl_m_oe(link.scl_m_oe),
    .sda_m_oe(link.sda_m_oe), .sda_s_oe(link.sda_s_oe), .scl(link.scl), .sda(link.sda));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic run_op(input logic [2:0] op, input logic [31:0] v);
    int n;
    wr_reg(`RHT_H_WDATA, v);
    wr_reg(`RHT_H_CTRL, {29'h0, op});
    n = 0;
    d = 32'h2;
    while (d[1] !== 1'b0)
    begin
      rd_reg(`RHT_H_CTRL, d);
      n++;
      if (n > 20000)
      begin
        fails++;
        stop_test();
      end
    end
    check({31'h0, d[0]}, 32'h0);
  endtask
  task automatic nvm_read(input logic [7:0] cmd, input logic [15:0] exp);
    run_op(OP_WRITE, {8'h0, cmd, 16'h0});
    run_op(OP_READ, 32'h0);
    rd_reg(`RHT_H_NVM, d);
    check(d, {16'h0, exp});
  endtask
  task automatic fetch_status(input logic [1:0] exp);
    run_op(OP_FETCH, 32'h0);
    rd_reg(`RHT_H_STAT, d);
    check({30'h0, d[1:0]}, {30'h0, exp});
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    fetch_status(`RHT_ST_STALE);
    check({28'h0, hum_res, temp_res}, 32'hf);
    run_op(OP_WRITE, {8'h0, `RHT_CMD_ENTER, 16'h0});
    check({31'h0, prog_mode}, 32'h1);
    nvm_read(`RHT_REG_ID_HI, ID[31:16]);
    nvm_read(`RHT_REG_ID_LO, ID[15:0]);
    nvm_read(`RHT_REG_TRES_RD, `RHT_RES_DEFAULT);
    nvm_read(`RHT_REG_HRES_RD, `RHT_RES_DEFAULT);
    wr_reg(`RHT_H_RES, 32'h1);
    run_op(OP_RMW, {8'h0, `RHT_REG_HRES_WR, 16'h0});
    check({28'h0, hum_res, temp_res}, 32'h7);
    nvm_read(`RHT_REG_HRES_RD, 16'h0400);
    run_op(OP_MEASURE, 32'h0);
    check({31'h0, meas_active}, 32'h0);
    run_op(OP_WRITE, {8'h0, `RHT_CMD_EXIT, 16'h0});
    check({31'h0, prog_mode}, 32'h0);
    // The power-up window has long run out, so a late entry must be ignored.
    run_op(OP_WRITE, {8'h0, `RHT_CMD_ENTER, 16'h0});
    check({31'h0, prog_mode}, 32'h0);
    run_op(OP_MEASURE, 32'h0);
    check({31'h0, meas_active}, 32'h1);
    repeat (400) @(posedge clk);
    check({31'h0, meas_active}, 32'h0);
    fetch_status(`RHT_ST_VALID);
    // Codes 0x2a5c and 0x1357 scale to 66.19 percent and 9.86 degrees in hundredths.
    rd_reg(`RHT_H_RH, d);
    check(d, 32'h0000_19db);
    rd_reg(`RHT_H_TEMP, d);
    check(d, 32'h0000_03da);
    fetch_status(`RHT_ST_STALE);
    stop_test();
  end
endmodule // rht_tb

// *** verilog/rht_if.sv ***
// Open-drain two-wire link between the bus master and the sensor.
// Each party pulls a line low by raising its output enable; pull-ups are implied.
`timescale 1ns/1ps
interface rht_if;
  logic scl_m_oe;
  logic sda_m_oe;
  logic sda_s_oe;
  logic scl;
  logic sda;
  assign scl = ~scl_m_oe;
  assign sda = ~(sda_m_oe | sda_s_oe);
  modport sensor (input scl, input sda, output sda_s_oe);
  modport master (input scl, input sda, output scl_m_oe, output sda_m_oe);
endinterface

// *** verilog/rht_master.sv ***
// Bus master end: runs sensor transactions ordered through a small register port.
// Assumes one master on the link and a sensor that never stretches the clock.
`timescale 1ns/1ps
`include "rht_params.svh"
module rht_master #(
  parameter int NVW_CYC = `RHT_T_NVW_MS * 1000 * `RHT_CLK_MHZ
) (
  input wire logic clk,
  input wire logic rstn,
  rht_if.master bus,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata
);
  import rht_pkg::*;

  rht_hst_t st, next_st;
  rht_op_t op, next_op;
  logic [23:0] wd, next_wd;
  logic [1:0] res, next_res, q, next_q;
  logic [15:0] nvm, next_nvm, hum_raw, next_hum_raw, tmp_raw, next_tmp_raw;
  logic [15:0] rh, next_rh, tc, next_tc;
  logic [31:0] rxw, next_rxw, next_rdata;
  logic [7:0] txsh, next_txsh, qc, next_qc;
  logic [3:0] bitn, next_bitn;
  logic [2:0] byten, next_byten, nbytes;
  logic scl_oe, next_scl_oe, sda_oe, next_sda_oe, err, next_err, tick, rdop, last;
  logic [19:0] hold, next_hold;
  logic [15:0] wd16;
  logic [31:0] rh_c, tc_c;

  assign bus.scl_m_oe = scl_oe;
  assign bus.sda_m_oe = sda_oe;
  assign tick = qc == 8'h0;
  assign rdop = (op == OP_FETCH) | (op == OP_READ);
  assign last = byten == nbytes - 3'h1;
  assign nbytes = (op == OP_MEASURE) ? 3'h1 : (op == OP_FETCH) ? 3'h5 : (op == OP_READ) ? 3'h3 : 3'h4;
  // Only bits 11 to 10 change; the rest comes back as last read.
  assign wd16 = (op == OP_RMW) ? {nvm[15:`RHT_RES_MSB + 1], res, nvm[`RHT_RES_LSB - 1:0]}
                : wd[15:0];
  assign rh_c = (32'(hum_raw[13:0]) * `RHT_RH_SPAN * `RHT_FRAC) / `RHT_CODE_FULL;
  // The low two bits of the last byte are undefined and dropped here.
  assign tc_c = (32'(tmp_raw[15:2]) * `RHT_T_SPAN * `RHT_FRAC) / `RHT_CODE_FULL
                - `RHT_T_OFFS * `RHT_FRAC;

  always_comb
  begin
    next_st = st;
    next_op = op;
    next_wd = wd;
    next_res = res;
    next_q = q;
    next_nvm = nvm;
    next_hum_raw = hum_raw;
    next_tmp_raw = tmp_raw;
    next_rh = rh;
    next_tc = tc;
    next_rxw = rxw;
    next_txsh = txsh;
    next_qc = tick ? 8'(`RHT_QTR_CYC - 1) : qc - 8'h1;
    next_bitn = bitn;
    next_byten = byten;
    next_scl_oe = scl_oe;
    next_sda_oe = sda_oe;
    next_err = err;
    next_hold = hold;
    next_rdata = 32'h0;
    if (rd)
    begin
      if (addr == `RHT_H_CTRL)
        next_rdata = {30'h0, st != H_IDLE, err};
      else if (addr == `RHT_H_WDATA)
        next_rdata = {8'h0, wd};
      else if (addr == `RHT_H_RES)
        next_rdata = {30'h0, res};
      else if (addr == `RHT_H_NVM)
        next_rdata = {16'h0, nvm};
      else if (addr == `RHT_H_RH)
        next_rdata = {16'h0, rh};
      else if (addr == `RHT_H_TEMP)
        next_rdata = {{16{tc[15]}}, tc};
      else if (addr == `RHT_H_STAT)
        next_rdata = {29'h0, hum_raw[15:14] == `RHT_ST_VALID, hum_raw[15:14]};
    end
    if (wr & (addr == `RHT_H_WDATA))
      next_wd = wdata[23:0];
    else if (wr & (addr == `RHT_H_RES))
      next_res = wdata[1:0];
    case (st)
      H_IDLE:
      begin
        if (wr & (addr == `RHT_H_CTRL) & (wdata[2:0] <= OP_RMW))
        begin
          next_op = rht_op_t'(wdata[2:0]);
          next_st = H_START;
          next_q = 2'h0;
          next_err = 1'b0;
          next_byten = 3'h0;
        end
      end
      H_START:
      begin
        if (tick)
        begin
          next_q = q + 2'h1;
          if (q == 2'h0)
            next_sda_oe = 1'b1;
          else if (q == 2'h1)
          begin
            next_scl_oe = 1'b1;
            next_st = H_BIT;
            next_q = 2'h0;
            next_bitn = 4'h0;
            next_txsh = {`RHT_DEV_ADDR, rdop};
          end
        end
      end
      H_BIT:
      begin
        if (tick)
        begin
          next_q = q + 2'h1;
          if (q == 2'h0)
          begin
            if (bitn != `RHT_BYTE_BITS)
              next_sda_oe = (rdop & (byten != 3'h0)) ? 1'b0 : ~txsh[7];
            else
              next_sda_oe = rdop & (byten != 3'h0) & ~last;
          end
          else if (q == 2'h1)
            next_scl_oe = 1'b0;
          else if (q == 2'h3)
          begin
            next_scl_oe = 1'b1;
            next_bitn = bitn + 4'h1;
            next_txsh = {txsh[6:0], 1'b0};
            if (bitn != `RHT_BYTE_BITS)
              next_rxw = {rxw[30:0], bus.sda};
            else
            begin
              next_bitn = 4'h0;
              next_byten = byten + 3'h1;
              if (byten == 3'h0)
                next_txsh = wd[23:16];
              else if (byten == 3'h1)
                next_txsh = wd16[15:8];
              else
                next_txsh = wd16[7:0];
              if (bus.sda & ~(rdop & (byten != 3'h0)))
                next_err = 1'b1;
              if (last | (bus.sda & ~(rdop & (byten != 3'h0))))
                next_st = H_STOP;
            end
          end
        end
      end
      H_STOP:
      begin
        if (tick)
        begin
          next_q = q + 2'h1;
          if (q == 2'h0)
            next_sda_oe = 1'b1;
          else if (q == 2'h1)
            next_scl_oe = 1'b0;
          else if (q == 2'h2)
            next_sda_oe = 1'b0;
          else
          begin
            next_st = H_HOLD;
            next_hold = 20'h1;
            if (op == OP_FETCH)
            begin
              next_hum_raw = rxw[31:16];
              next_tmp_raw = rxw[15:0];
            end
            else if (op == OP_READ)
              next_nvm = rxw[15:0];
            else if ((op == OP_RMW) | (wd[23:16] == `RHT_REG_HRES_WR)
                     | (wd[23:16] == `RHT_REG_TRES_WR))
              next_hold = 20'(NVW_CYC);
            else if (op == OP_WRITE)
              next_hold = 20'(`RHT_LOAD_CYC);
          end
        end
      end
      H_HOLD:
      begin
        next_hold = hold - 20'h1;
        next_rh = 16'(rh_c);
        next_tc = 16'(tc_c);
        if (hold == 20'h1)
          next_st = H_IDLE;
      end
      default:
        next_st = H_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= H_IDLE;
      op <= OP_MEASURE;
      wd <= 24'h0;
      res <= 2'h3;
      q <= 2'h0;
      nvm <= 16'h0;
      hum_raw <= 16'h4000;
      tmp_raw <= 16'h0;
      rh <= 16'h0;
      tc <= 16'h0;
      rxw <= 32'h0;
      txsh <= 8'h0;
      qc <= 8'h0;
      bitn <= 4'h0;
      byten <= 3'h0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      err <= 1'b0;
      hold <= 20'h0;
      rdata <= 32'h0;
    end
    else
    begin
      st <= next_st;
      op <= next_op;
      wd <= next_wd;
      res <= next_res;
      q <= next_q;
      nvm <= next_nvm;
      hum_raw <= next_hum_raw;
      tmp_raw <= next_tmp_raw;
      rh <= next_rh;
      tc <= next_tc;
      rxw <= next_rxw;
      txsh <= next_txsh;
      qc <= next_qc;
      bitn <= next_bitn;
      byten <= next_byten;
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
      err <= next_err;
      hold <= next_hold;
      rdata <= next_rdata;
    end
  end
endmodule // rht_master

// *** verilog/rht_params.svh ***
// Constants shared by the sensor end and the bus master end of the link.
// Assumes a 25 MHz system clock on both ends.
`ifndef RHT_PARAMS_SVH
`define RHT_PARAMS_SVH
`define RHT_CLK_MHZ 25
`define RHT_CLK_NS 40
`define RHT_DEV_ADDR 7'h44
`define RHT_CMD_ENTER 8'ha0
`define RHT_CMD_EXIT 8'h80
`define RHT_REG_HRES_RD 8'h06
`define RHT_REG_TRES_RD 8'h11
`define RHT_REG_ID_HI 8'h1e
`define RHT_REG_ID_LO 8'h1f
`define RHT_REG_HRES_WR 8'h46
`define RHT_REG_TRES_WR 8'h51
`define RHT_RES_DEFAULT 16'h0c00
`define RHT_RES_LSB 10
`define RHT_RES_MSB 11
`define RHT_ST_VALID 2'h0
`define RHT_ST_STALE 2'h1
// Arbitrary identification value, not that of any real part.
`define RHT_ID_DEFAULT 32'h1234_5678
`define RHT_BYTE_BITS 4'h8
`define RHT_T_WIN_MS 10
`define RHT_T_LOAD_US 120
`define RHT_T_NVW_MS 14
`define RHT_T_MEAS_MS 35
`define RHT_LOAD_CYC (`RHT_T_LOAD_US * `RHT_CLK_MHZ)
`define RHT_T_QTR_NS 640
`define RHT_QTR_CYC (`RHT_T_QTR_NS / `RHT_CLK_NS)
`define RHT_CODE_FULL 16383
`define RHT_RH_SPAN 100
`define RHT_T_SPAN 165
`define RHT_T_OFFS 40
`define RHT_FRAC 100
`define RHT_H_CTRL 8'h00
`define RHT_H_WDATA 8'h04
`define RHT_H_RES 8'h08
`define RHT_H_NVM 8'h0c
`define RHT_H_RH 8'h10
`define RHT_H_TEMP 8'h14
`define RHT_H_STAT 8'h18
`endif

// *** verilog/rht_pkg.sv ***
// Types shared by both ends of the humidity sensor link.
// Assumes rht_params.svh holds the numeric constants.
package rht_pkg;
  typedef logic [1:0] rht_res_t;
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_ADDR = 7'h02,
    S_RX = 7'h04,
    S_ACK = 7'h08,
    S_TX = 7'h10,
    S_MACK = 7'h20,
    S_WAIT = 7'h40
  } rht_sst_t;
  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_START = 5'h02,
    H_BIT = 5'h04,
    H_STOP = 5'h08,
    H_HOLD = 5'h10
  } rht_hst_t;
  typedef enum logic [2:0] {
    OP_MEASURE = 3'h0,
    OP_FETCH = 3'h1,
    OP_WRITE = 3'h2,
    OP_READ = 3'h3,
    OP_RMW = 3'h4
  } rht_op_t;
endpackage

// *** verilog/rht_sensor.sv ***
// Sensor end: two-wire slave, measurement output and programming-mode registers.
// Assumes the line levels are synchronous to clk and the master never stretches.
`timescale 1ns/1ps
`include "rht_params.svh"
module rht_sensor #(
  parameter int WIN_CYC = `RHT_T_WIN_MS * 1000 * `RHT_CLK_MHZ,
  parameter int NVW_CYC = `RHT_T_NVW_MS * 1000 * `RHT_CLK_MHZ,
  parameter int MEAS_CYC = `RHT_T_MEAS_MS * 1000 * `RHT_CLK_MHZ,
  parameter logic [31:0] ID_VALUE = `RHT_ID_DEFAULT
) (
  input wire logic clk,
  input wire logic rstn,
  rht_if.sensor bus,
  input wire logic [13:0] hum_code,
  input wire logic [13:0] temp_code,
  output logic meas_active,
  output logic prog_mode,
  output rht_pkg::rht_res_t hum_res,
  output rht_pkg::rht_res_t temp_res
);
  import rht_pkg::*;

  localparam logic [1:0] JOB_MEAS = 2'h0;
  localparam logic [1:0] JOB_LOAD = 2'h1;
  localparam logic [1:0] JOB_WRITE = 2'h2;
  localparam logic [1:0] JOB_ENTER = 2'h3;

  rht_sst_t st, next_st;
  logic scl_q, sda_q, next_scl_q, next_sda_q;
  logic [7:0] sh, next_sh, txsh, next_txsh;
  logic [7:0] cmd, next_cmd, dhi, next_dhi, dlo, next_dlo;
  logic [3:0] bcnt, next_bcnt;
  logic [1:0] nrx, next_nrx, bidx, next_bidx, job, next_job;
  logic rw, next_rw, matched, next_matched, mack, next_mack;
  logic sda_oe, next_sda_oe, stale, next_stale, meas, next_meas, prog, next_prog;
  logic [13:0] hum_r, next_hum_r, tmp_r, next_tmp_r;
  logic [15:0] hreg, next_hreg, treg, next_treg, nvm, next_nvm;
  logic [19:0] tmr, next_tmr, win, next_win;
  logic scl_rise, scl_fall, start_c, stop_c, busy;

  assign scl_rise = ~scl_q & bus.scl;
  assign scl_fall = scl_q & ~bus.scl;
  assign start_c = scl_q & bus.scl & sda_q & ~bus.sda;
  assign stop_c = scl_q & bus.scl & ~sda_q & bus.sda;
  assign busy = tmr != 20'h0;
  assign bus.sda_s_oe = sda_oe;
  assign meas_active = meas;
  assign prog_mode = prog;
  assign hum_res = hreg[`RHT_RES_MSB:`RHT_RES_LSB];
  assign temp_res = treg[`RHT_RES_MSB:`RHT_RES_LSB];

  // Byte sent at position idx of a read transaction; the index wraps after four.
  function automatic logic [7:0] tx_byte(input logic [1:0] idx);
    logic [7:0] b;
    b = 8'h00;
    if (prog)
    begin
      if (idx == 2'h0)
        b = nvm[15:8];
      else if (idx == 2'h1)
        b = nvm[7:0];
    end
    else if (idx == 2'h0)
      b = {(stale ? `RHT_ST_STALE : `RHT_ST_VALID), hum_r[13:8]};
    else if (idx == 2'h1)
      b = hum_r[7:0];
    else if (idx == 2'h2)
      b = tmp_r[13:6];
    else
      b = {tmp_r[5:0], 2'h0};
    return b;
  endfunction

  // Register selected by a read-address command.
  function automatic logic [15:0] nvm_sel(input logic [7:0] a);
    logic [15:0] v;
    v = 16'h0000;
    if (a == `RHT_REG_HRES_RD)
      v = hreg;
    else if (a == `RHT_REG_TRES_RD)
      v = treg;
    else if (a == `RHT_REG_ID_HI)
      v = ID_VALUE[31:16];
    else if (a == `RHT_REG_ID_LO)
      v = ID_VALUE[15:0];
    return v;
  endfunction

  always_comb
  begin
    next_st = st;
    next_scl_q = bus.scl;
    next_sda_q = bus.sda;
    next_sh = sh;
    next_txsh = txsh;
    next_cmd = cmd;
    next_dhi = dhi;
    next_dlo = dlo;
    next_bcnt = bcnt;
    next_nrx = nrx;
    next_bidx = bidx;
    next_job = job;
    next_rw = rw;
    next_matched = matched;
    next_mack = mack;
    next_sda_oe = sda_oe;
    next_stale = stale;
    next_meas = meas;
    next_prog = prog;
    next_hum_r = hum_r;
    next_tmp_r = tmp_r;
    next_hreg = hreg;
    next_treg = treg;
    next_nvm = nvm;
    next_tmr = busy ? tmr - 20'h1 : tmr;
    next_win = (win != 20'h0) ? win - 20'h1 : win;
    if (tmr == 20'h1)
    begin
      if (job == JOB_MEAS)
      begin
        next_meas = 1'b0;
        next_hum_r = hum_code;
        next_tmp_r = temp_code;
        next_stale = 1'b0;
      end
      else if (job == JOB_LOAD)
        next_nvm = nvm_sel(cmd);
      else if (job == JOB_WRITE)
      begin
        if (cmd == `RHT_REG_HRES_WR)
          next_hreg = {dhi, dlo};
        else
          next_treg = {dhi, dlo};
      end
    end
    if (start_c)
    begin
      next_st = S_ADDR;
      next_bcnt = 4'h0;
      next_nrx = 2'h0;
      next_sda_oe = 1'b0;
    end
    else if (stop_c)
    begin
      next_st = S_IDLE;
      next_sda_oe = 1'b0;
      next_matched = 1'b0;
      if (matched & ~rw & (nrx == 2'h0) & ~prog)
      begin
        next_meas = 1'b1;
        next_tmr = 20'(MEAS_CYC);
        next_job = JOB_MEAS;
      end
      else if (matched & ~rw & (nrx == 2'h3))
      begin
        if ((cmd == `RHT_CMD_ENTER) & ({dhi, dlo} == 16'h0000) & ~prog & (win != 20'h0))
        begin
          next_prog = 1'b1;
          next_tmr = 20'(`RHT_LOAD_CYC);
          next_job = JOB_ENTER;
        end
        else if (prog & (cmd == `RHT_CMD_EXIT) & ({dhi, dlo} == 16'h0000))
          next_prog = 1'b0;
        else if (prog & ((cmd == `RHT_REG_HRES_WR) | (cmd == `RHT_REG_TRES_WR)))
        begin
          next_tmr = 20'(NVW_CYC);
          next_job = JOB_WRITE;
        end
        else if (prog & ((cmd == `RHT_REG_HRES_RD) | (cmd == `RHT_REG_TRES_RD)
                 | (cmd == `RHT_REG_ID_HI) | (cmd == `RHT_REG_ID_LO)))
        begin
          next_tmr = 20'(`RHT_LOAD_CYC);
          next_job = JOB_LOAD;
        end
      end
    end
    else
    begin
      case (st)
        S_ADDR, S_RX:
        begin
          if (scl_rise)
          begin
            next_sh = {sh[6:0], bus.sda};
            next_bcnt = bcnt + 4'h1;
          end
          else if (scl_fall & (bcnt == `RHT_BYTE_BITS))
          begin
            next_bcnt = 4'h0;
            if (st == S_ADDR)
            begin
              // A busy sensor refuses its address, so no access can disturb a pending job.
              next_matched = (sh[7:1] == `RHT_DEV_ADDR) & ~busy;
              next_rw = sh[0];
              next_sda_oe = (sh[7:1] == `RHT_DEV_ADDR) & ~busy;
              next_st = ((sh[7:1] == `RHT_DEV_ADDR) & ~busy) ? S_ACK : S_WAIT;
            end
            else
            begin
              if (nrx == 2'h0)
                next_cmd = sh;
              else if (nrx == 2'h1)
                next_dhi = sh;
              else if (nrx == 2'h2)
                next_dlo = sh;
              if (nrx != 2'h3)
                next_nrx = nrx + 2'h1;
              next_sda_oe = 1'b1;
              next_st = S_ACK;
            end
          end
        end
        S_ACK:
        begin
          if (scl_fall)
          begin
            if (rw)
            begin
              next_bidx = 2'h0;
              next_txsh = tx_byte(2'h0);
              next_sda_oe = ~next_txsh[7];
              next_st = S_TX;
              if (~prog)
                next_stale = 1'b1;
            end
            else
            begin
              next_sda_oe = 1'b0;
              next_st = S_RX;
            end
          end
        end
        S_TX:
        begin
          if (scl_rise)
            next_bcnt = bcnt + 4'h1;
          else if (scl_fall)
          begin
            if (bcnt == `RHT_BYTE_BITS)
            begin
              next_sda_oe = 1'b0;
              next_st = S_MACK;
            end
            else
            begin
              next_sda_oe = ~txsh[6];
              next_txsh = {txsh[6:0], 1'b0};
            end
          end
        end
        S_MACK:
        begin
          if (scl_rise)
            next_mack = ~bus.sda;
          else if (scl_fall)
          begin
            if (mack)
            begin
              next_bidx = bidx + 2'h1;
              next_txsh = tx_byte(bidx + 2'h1);
              next_sda_oe = ~next_txsh[7];
              next_bcnt = 4'h0;
              next_st = S_TX;
            end
            else
              next_st = S_WAIT;
          end
        end
        default:
          next_st = st;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= S_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sh <= 8'h00;
      txsh <= 8'h00;
      cmd <= 8'h00;
      dhi <= 8'h00;
      dlo <= 8'h00;
      bcnt <= 4'h0;
      nrx <= 2'h0;
      bidx <= 2'h0;
      job <= JOB_MEAS;
      rw <= 1'b0;
      matched <= 1'b0;
      mack <= 1'b0;
      sda_oe <= 1'b0;
      stale <= 1'b1;
      meas <= 1'b0;
      prog <= 1'b0;
      hum_r <= 14'h0000;
      tmp_r <= 14'h0000;
      hreg <= `RHT_RES_DEFAULT;
      treg <= `RHT_RES_DEFAULT;
      nvm <= 16'h0000;
      tmr <= 20'h0;
      win <= 20'(WIN_CYC);
    end
    else
    begin
      st <= next_st;
      scl_q <= next_scl_q;
      sda_q <= next_sda_q;
      sh <= next_sh;
      txsh <= next_txsh;
      cmd <= next_cmd;
      dhi <= next_dhi;
      dlo <= next_dlo;
      bcnt <= next_bcnt;
      nrx <= next_nrx;
      bidx <= next_bidx;
      job <= next_job;
      rw <= next_rw;
      matched <= next_matched;
      mack <= next_mack;
      sda_oe <= next_sda_oe;
      stale <= next_stale;
      meas <= next_meas;
      prog <= next_prog;
      hum_r <= next_hum_r;
      tmp_r <= next_tmp_r;
      hreg <= next_hreg;
      treg <= next_treg;
      nvm <= next_nvm;
      tmr <= next_tmr;
      win <= next_win;
    end
  end
endmodule // rht_sensor
